//--- logic/sxalu_calc.sv
`timescale 1ns/1ps
// Combinational result and flag computation
module sxalu_calc (
   sxalu_op_if.unit io
);
   logic [8:0] diff;
   logic [4:0] ndiff;

   // Borrow-free subtract: bit 8 high means no borrow
   assign diff = {1'b0, io.reg_val} + {1'b0, ~io.acc} + 9'h001;
   assign ndiff = {1'b0, io.reg_val[3:0]} + {1'b0, ~io.acc[3:0]} + 5'h01;

   // Result selection per operation
   always_comb begin
      io.result = 8'h00;
      io.upd_c_dc = 1'b0;
      io.upd_z = 1'b0;
      case (io.op)
         sxalu_pkg::SXALU_OP_SUB_ACC_FROM_REG: begin
            io.result = diff[7:0];
            io.upd_c_dc = 1'b1;
            io.upd_z = 1'b1;
         end
         sxalu_pkg::SXALU_OP_XOR_IMMEDIATE: begin
            io.result = io.acc ^ io.literal;
            io.upd_z = 1'b1;
         end
         sxalu_pkg::SXALU_OP_XOR_REG: begin
            io.result = io.acc ^ io.reg_val;
            io.upd_z = 1'b1;
         end
         sxalu_pkg::SXALU_OP_NIBBLE_SWAP: begin
            io.result = {io.reg_val[3:0], io.reg_val[7:4]};
         end
         default: begin
            io.result = 8'h00;
         end
      endcase
   end

   assign io.carry = diff[8];
   assign io.digit_carry = ndiff[4];
   assign io.zero = (io.result == 8'h00);
endmodule

//--- logic/sxalu_op_if.sv
`timescale 1ns/1ps
// Operands and results passed between the core and its arithmetic unit
interface sxalu_op_if;
   sxalu_pkg::sxalu_op_e op;
   logic [7:0] acc;
   logic [7:0] reg_val;
   logic [7:0] literal;
   logic [7:0] result;
   logic carry;
   logic digit_carry;
   logic zero;
   logic upd_c_dc;
   logic upd_z;
   modport core (output op, acc, reg_val, literal,
                 input result, carry, digit_carry, zero, upd_c_dc, upd_z);
   modport unit (input op, acc, reg_val, literal,
                 output result, carry, digit_carry, zero, upd_c_dc, upd_z);
endinterface

//--- logic/sxalu_pkg.sv
package sxalu_pkg;
   // Operation select codes from the instruction decoder
   typedef enum logic [2:0] {
      SXALU_OP_NONE,
      SXALU_OP_SUB_ACC_FROM_REG,
      SXALU_OP_XOR_IMMEDIATE,
      SXALU_OP_NIBBLE_SWAP,
      SXALU_OP_XOR_REG
   } sxalu_op_e;
   localparam int SXALU_DATA_W = 8;
   localparam int SXALU_ADDR_W = 7;
   localparam int SXALU_NIB_LO = 0;
   localparam int SXALU_NIB_HI = 4;
   localparam logic [7:0] SXALU_ACC_RST = 8'h00;
   localparam logic SXALU_FLAG_RST = 1'b0;
   localparam logic SXALU_DEST_ACC = 1'b0;
   localparam logic SXALU_DEST_REG = 1'b1;
endpackage

//--- logic/sxalu_top.sv
`timescale 1ns/1ps
// What this block does
// - Subtract operation computes register minus accumulator, two's complement, 8 bits.
// - Destination bit zero writes accumulator; one writes back the addressed register.
// - Subtract sets digit carry when accumulator low nibble <= register low nibble.
// - Immediate XOR combines accumulator with literal, result always to accumulator.
// - Nibble swap exchanges register halves, routes by destination, flags untouched.
// - Register XOR combines accumulator with register, routed by destination bit.
module sxalu_top (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic op_valid,
   input wire sxalu_pkg::sxalu_op_e op_sel,
   input wire logic dest_sel,
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_rdata,
   input wire logic [7:0] literal,
   output logic [7:0] acc_q,
   output logic carry_flag_q,
   output logic digit_carry_flag_q,
   output logic zero_flag_q,
   output logic reg_we_q,
   output logic [6:0] reg_waddr_q,
   output logic [7:0] reg_wdata_q
);
   sxalu_op_if alu_if ();
   logic fire;
   logic to_reg;

   // Operand hookup for the arithmetic unit
   assign alu_if.op = op_valid ? op_sel : sxalu_pkg::SXALU_OP_NONE;
   assign alu_if.acc = acc_q;
   assign alu_if.reg_val = reg_rdata;
   assign alu_if.literal = literal;

   sxalu_calc u_calc (
      .io(alu_if)
   );

   // Immediate XOR ignores the destination bit
   assign fire = op_valid && (op_sel != sxalu_pkg::SXALU_OP_NONE);
   assign to_reg = fire && (dest_sel == sxalu_pkg::SXALU_DEST_REG)
                   && (op_sel != sxalu_pkg::SXALU_OP_XOR_IMMEDIATE);

   // Accumulator update
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         acc_q <= sxalu_pkg::SXALU_ACC_RST;
      end else if (fire && !to_reg) begin
         acc_q <= alu_if.result;
      end
   end

   // File register write-back port
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_we_q <= 1'b0;
         reg_waddr_q <= 7'h00;
         reg_wdata_q <= 8'h00;
      end else begin
         reg_we_q <= to_reg;
         if (to_reg) begin
            reg_waddr_q <= reg_addr;
            reg_wdata_q <= alu_if.result;
         end
      end
   end

   // Status flags
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         carry_flag_q <= sxalu_pkg::SXALU_FLAG_RST;
         digit_carry_flag_q <= sxalu_pkg::SXALU_FLAG_RST;
         zero_flag_q <= sxalu_pkg::SXALU_FLAG_RST;
      end else begin
         if (alu_if.upd_c_dc) begin
            carry_flag_q <= alu_if.carry;
            digit_carry_flag_q <= alu_if.digit_carry;
         end
         if (alu_if.upd_z) begin
            zero_flag_q <= alu_if.zero;
         end
      end
   end

   // Checks
   sequence s_sub_issued;
      op_valid && op_sel == sxalu_pkg::SXALU_OP_SUB_ACC_FROM_REG;
   endsequence

   AST_SUB_RESULT: assert property (@(posedge clk) disable iff (sys_rst)
      s_sub_issued ##0 (dest_sel == 1'b0) |=>
      acc_q == 8'($past(reg_rdata) - $past(acc_q)))
      else $error("subtract result wrong");
   AST_DEST_REG: assert property (@(posedge clk) disable iff (sys_rst)
      (op_valid && op_sel == sxalu_pkg::SXALU_OP_XOR_REG && dest_sel) |=>
      (reg_we_q && $stable(acc_q) && reg_waddr_q == $past(reg_addr)))
      else $error("register destination not honoured");
   AST_DC: assert property (@(posedge clk) disable iff (sys_rst)
      s_sub_issued |=> digit_carry_flag_q == ($past(acc_q[3:0]) <= $past(reg_rdata[3:0])))
      else $error("digit carry wrong");
   AST_XORI: assert property (@(posedge clk) disable iff (sys_rst)
      (op_valid && op_sel == sxalu_pkg::SXALU_OP_XOR_IMMEDIATE) |=>
      (!reg_we_q && acc_q == ($past(acc_q) ^ $past(literal))))
      else $error("immediate xor wrong");
   AST_SWAP_FLAGS: assert property (@(posedge clk) disable iff (sys_rst)
      (op_valid && op_sel == sxalu_pkg::SXALU_OP_NIBBLE_SWAP) |=>
      ($stable(carry_flag_q) && $stable(digit_carry_flag_q) && $stable(zero_flag_q)))
      else $error("swap changed flags");
   AST_SWAP_DATA: assert property (@(posedge clk) disable iff (sys_rst)
      (op_valid && op_sel == sxalu_pkg::SXALU_OP_NIBBLE_SWAP && dest_sel) |=>
      reg_wdata_q == {$past(reg_rdata[3:0]), $past(reg_rdata[7:4])})
      else $error("swap data wrong");
   AST_XORR: assert property (@(posedge clk) disable iff (sys_rst)
      (op_valid && op_sel == sxalu_pkg::SXALU_OP_XOR_REG && !dest_sel) |=>
      acc_q == ($past(acc_q) ^ $past(reg_rdata)))
      else $error("register xor wrong");
   AST_CARRY: assert property (@(posedge clk) disable iff (sys_rst)
      s_sub_issued |=> carry_flag_q == ($past(acc_q) <= $past(reg_rdata)))
      else $error("carry wrong");
   AST_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
      (op_valid && op_sel == sxalu_pkg::SXALU_OP_XOR_REG && dest_sel) |=>
      zero_flag_q == (reg_wdata_q == 8'h00))
      else $error("zero flag wrong");

   // Reference results for the checks, kept apart from the datapath
   function automatic logic [7:0] sxalu_ref_sub(input logic [7:0] lhs, input logic [7:0] rhs);
      return 8'(lhs - rhs);
   endfunction

   // Byte with its two halves traded
   function automatic logic [7:0] sxalu_ref_swap(input logic [7:0] val);
      return {val[3:0], val[7:4]};
   endfunction

   // Accepted operation of the wanted kind, outside reset
   function automatic logic sxalu_issued(input logic valid, input logic rst,
         input sxalu_pkg::sxalu_op_e sel, input sxalu_pkg::sxalu_op_e want);
      return valid && !rst && (sel == want);
   endfunction

   // Issue of each kind of operation
   sequence s_sub_taken;
      sxalu_issued(op_valid, sys_rst, op_sel, sxalu_pkg::SXALU_OP_SUB_ACC_FROM_REG);
   endsequence
   sequence s_xori_taken;
      sxalu_issued(op_valid, sys_rst, op_sel, sxalu_pkg::SXALU_OP_XOR_IMMEDIATE);
   endsequence
   sequence s_swap_taken;
      sxalu_issued(op_valid, sys_rst, op_sel, sxalu_pkg::SXALU_OP_NIBBLE_SWAP);
   endsequence
   sequence s_xorr_taken;
      sxalu_issued(op_valid, sys_rst, op_sel, sxalu_pkg::SXALU_OP_XOR_REG);
   endsequence

   // Destination choice sampled with the issue
   sequence s_to_acc;
      dest_sel == sxalu_pkg::SXALU_DEST_ACC;
   endsequence
   sequence s_to_reg;
      dest_sel == sxalu_pkg::SXALU_DEST_REG;
   endsequence

   // Write-back strobe carrying the address of the issue cycle
   sequence s_reg_written;
      reg_we_q && (reg_waddr_q == $past(reg_addr));
   endsequence

   // Subtract sent to the register leaves the accumulator alone
   AST_SUB_TO_REG: assert property (@(posedge clk) disable iff (sys_rst)
      s_sub_taken ##0 s_to_reg |=> s_reg_written ##0 $stable(acc_q)
      ##0 (reg_wdata_q == sxalu_ref_sub($past(reg_rdata), $past(acc_q))))
      else $error("subtract write-back wrong");

   // Zero follows the subtract result, whichever way it is routed
   AST_SUB_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
      s_sub_taken |=> zero_flag_q == (sxalu_ref_sub($past(reg_rdata), $past(acc_q)) == 8'h00))
      else $error("subtract zero flag wrong");

   // Zero follows the immediate exclusive OR
   AST_XORI_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
      s_xori_taken |=> zero_flag_q == (($past(acc_q) ^ $past(literal)) == 8'h00))
      else $error("immediate xor zero flag wrong");

   // Immediate form never writes the register, even with the destination bit set
   AST_XORI_NO_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
      s_xori_taken ##0 s_to_reg |=> !reg_we_q)
      else $error("immediate xor wrote the register");

   // Swap into the accumulator, no write-back
   AST_SWAP_TO_ACC: assert property (@(posedge clk) disable iff (sys_rst)
      s_swap_taken ##0 s_to_acc |=> !reg_we_q && (acc_q == sxalu_ref_swap($past(reg_rdata))))
      else $error("swap to accumulator wrong");

   // Swap into the register, accumulator held
   AST_SWAP_TO_REG: assert property (@(posedge clk) disable iff (sys_rst)
      s_swap_taken ##0 s_to_reg |=> s_reg_written ##0 $stable(acc_q))
      else $error("swap write-back wrong");

   // Register exclusive OR written back
   AST_XORR_TO_REG: assert property (@(posedge clk) disable iff (sys_rst)
      s_xorr_taken ##0 s_to_reg |=> reg_wdata_q == ($past(acc_q) ^ $past(reg_rdata)))
      else $error("register xor write-back wrong");

   // Zero follows the register exclusive OR
   AST_XORR_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
      s_xorr_taken |=> zero_flag_q == (($past(acc_q) ^ $past(reg_rdata)) == 8'h00))
      else $error("register xor zero flag wrong");

   // Accumulator destination never raises the write strobe
   AST_ACC_NO_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
      (op_valid && !sys_rst && (op_sel != sxalu_pkg::SXALU_OP_NONE)
      && (dest_sel == sxalu_pkg::SXALU_DEST_ACC)) |=> !reg_we_q)
      else $error("accumulator destination wrote the register");

   // An idle cycle leaves the accumulator and the strobe quiet
   AST_IDLE_QUIET: assert property (@(posedge clk) disable iff (sys_rst)
      (!sys_rst && !(op_valid && (op_sel != sxalu_pkg::SXALU_OP_NONE))) |=>
      (!reg_we_q && $stable(acc_q)))
      else $error("idle cycle changed state");

   // Write address and data hold between register writes
   AST_PORT_HOLDS: assert property (@(posedge clk) disable iff (sys_rst)
      (!sys_rst && !(op_valid && (dest_sel == sxalu_pkg::SXALU_DEST_REG)
      && (op_sel != sxalu_pkg::SXALU_OP_NONE)
      && (op_sel != sxalu_pkg::SXALU_OP_XOR_IMMEDIATE))) |=>
      ($stable(reg_waddr_q) && $stable(reg_wdata_q)))
      else $error("write port moved without a write");
endmodule

//--- test/subtract_xor_swap_alu_ops_bench.sv
`timescale 1ns/1ps
module subtract_xor_swap_alu_ops_bench;
   typedef sxalu_pkg::sxalu_op_e sxalu_op_t;
   localparam sxalu_op_t op_no = sxalu_pkg::SXALU_OP_NONE;
   localparam sxalu_op_t op_sb = sxalu_pkg::SXALU_OP_SUB_ACC_FROM_REG;
   localparam sxalu_op_t op_xi = sxalu_pkg::SXALU_OP_XOR_IMMEDIATE;
   localparam sxalu_op_t op_sw = sxalu_pkg::SXALU_OP_NIBBLE_SWAP;
   localparam sxalu_op_t op_xr = sxalu_pkg::SXALU_OP_XOR_REG;
   typedef struct {sxalu_op_t op; logic d; logic [6:0] a; logic [7:0] k, acc;
      logic c, dc, z, we; logic [7:0] wd;} sxalu_row_s;
   logic clk, sys_rst, op_valid, dest_sel, reg_we_q, c_q, dc_q, z_q;
   sxalu_op_t op_sel;
   logic [6:0] reg_addr, reg_waddr_q;
   logic [7:0] reg_rdata, literal, acc_q, reg_wdata_q;
   int error_cnt = 0;
   int tests_run = 0;
   // Operation, dest, addr, literal, then expected acc, c, dc, z, we, wdata
   sxalu_row_s rows [16] = '{
      '{op_xi, 0, 7'h00, 8'h5A, 8'h5A, 0, 0, 0, 0, 8'h00},
      '{op_xi, 0, 7'h00, 8'h5A, 8'h00, 0, 0, 1, 0, 8'h00},
      '{op_xi, 1, 7'h05, 8'h13, 8'h13, 0, 0, 0, 0, 8'h00},
      '{op_sb, 0, 7'h25, 8'h00, 8'h12, 1, 1, 0, 0, 8'h00},
      '{op_sb, 1, 7'h12, 8'h00, 8'h12, 1, 1, 1, 1, 8'h00},
      '{op_sw, 1, 7'h34, 8'h00, 8'h12, 1, 1, 1, 1, 8'h43},
      '{op_sw, 0, 7'h34, 8'h00, 8'h34, 1, 1, 1, 0, 8'h00},
      '{op_sb, 0, 7'h01, 8'h00, 8'hCD, 0, 0, 0, 0, 8'h00},
      '{op_xr, 1, 7'h34, 8'h00, 8'hCD, 0, 0, 0, 1, 8'h8E},
      '{op_xr, 0, 7'h34, 8'h00, 8'h43, 0, 0, 0, 0, 8'h00},
      '{op_xr, 0, 7'h43, 8'h00, 8'h00, 0, 0, 1, 0, 8'h00},
      '{op_no, 1, 7'h10, 8'hFF, 8'h00, 0, 0, 1, 0, 8'h00},
      '{op_xi, 0, 7'h00, 8'h1F, 8'h1F, 0, 0, 0, 0, 8'h00},
      '{op_sb, 0, 7'h20, 8'h00, 8'h01, 1, 0, 0, 0, 8'h00},
      '{op_xi, 0, 7'h00, 8'h31, 8'h30, 1, 0, 0, 0, 8'h00},
      '{op_sb, 1, 7'h05, 8'h00, 8'h30, 0, 1, 0, 1, 8'hD5}};

   sxalu_top u_dut (.clk(clk), .sys_rst(sys_rst), .op_valid(op_valid), .op_sel(op_sel),
      .dest_sel(dest_sel), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .literal(literal),
      .acc_q(acc_q), .carry_flag_q(c_q), .digit_carry_flag_q(dc_q), .zero_flag_q(z_q),
      .reg_we_q(reg_we_q), .reg_waddr_q(reg_waddr_q), .reg_wdata_q(reg_wdata_q));
   sxalu_regbank u_bank (.clk(clk), .sys_rst(sys_rst), .rd_addr(reg_addr), .we(reg_we_q),
      .waddr(reg_waddr_q), .wdata(reg_wdata_q), .rdata(reg_rdata));

   // Byte and bit compares
   task automatic chk8(string n, logic [7:0] e, logic [7:0] s);
      tests_run++;
      if (s !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic chk1(string n, logic e, logic s);
      tests_run++;
      if (s !== e) begin
         error_cnt++;
         $display("wrong value %s expected %b seen %b", n, e, s);
      end
   endtask
   // Issue one operation at the next edge
   task automatic drv(sxalu_row_s r);
      @(posedge clk);
      op_valid <= 1'b1;
      op_sel <= r.op;
      dest_sel <= r.d;
      reg_addr <= r.a;
      literal <= r.k;
   endtask
   task automatic settle();
      @(posedge clk);
      op_valid <= 1'b0;
      #1;
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Table, back-to-back issue, then reset in mid-run
   initial begin
      {op_valid, dest_sel, reg_addr, literal} = '0;
      op_sel = op_no;
      sys_rst = 1'b1;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      foreach (rows[i]) begin
         drv(rows[i]);
         settle();
         chk8("acc", rows[i].acc, acc_q);
         chk1("carry", rows[i].c, c_q);
         chk1("digit carry", rows[i].dc, dc_q);
         chk1("zero", rows[i].z, z_q);
         chk1("write strobe", rows[i].we, reg_we_q);
         if (rows[i].we) begin
            chk8("write data", rows[i].wd, reg_wdata_q);
            chk8("write addr", {1'b0, rows[i].a}, {1'b0, reg_waddr_q});
         end
      end
      drv('{op_xi, 0, 7'h00, 8'h0F, 8'h00, 0, 0, 0, 0, 8'h00});
      drv('{op_xi, 0, 7'h00, 8'h3F, 8'h00, 0, 0, 0, 0, 8'h00});
      settle();
      chk8("acc", 8'h00, acc_q);
      chk1("zero", 1'b1, z_q);
      // Swap into the accumulator keeps the zero and digit carry flags
      drv('{op_sw, 0, 7'h21, 8'h00, 8'h00, 0, 0, 0, 0, 8'h00});
      settle();
      chk8("acc", 8'h12, acc_q);
      chk1("zero", 1'b1, z_q);
      chk1("digit carry", 1'b1, dc_q);
      // Reset in mid-run, then an operation at the first edge after release
      @(posedge clk);
      sys_rst <= 1'b1;
      @(posedge clk);
      sys_rst <= 1'b0;
      op_valid <= 1'b1;
      op_sel <= op_xi;
      literal <= 8'h3C;
      #1;
      chk8("acc", 8'h00, acc_q);
      chk1("carry", 1'b0, c_q);
      chk1("digit carry", 1'b0, dc_q);
      chk1("zero", 1'b0, z_q);
      chk1("write strobe", 1'b0, reg_we_q);
      chk8("write addr", 8'h00, {1'b0, reg_waddr_q});
      chk8("write data", 8'h00, reg_wdata_q);
      settle();
      chk8("acc", 8'h3C, acc_q);
      chk1("zero", 1'b0, z_q);
      complete_run();
   end
endmodule

//--- test/sxalu_regbank.sv
`timescale 1ns/1ps
// File register bank model: combinational read, write on strobe
module sxalu_regbank (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [6:0] rd_addr,
   input wire logic we,
   input wire logic [6:0] waddr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   logic [7:0] mem_q [128];
   // Each location resets to its own address
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < 128; i++) begin
            mem_q[i] <= 8'(i);
         end
      end else if (we) begin
         mem_q[waddr] <= wdata;
      end
   end
   assign rdata = mem_q[rd_addr];
endmodule
